// [rtl/adcdc_chan.sv]
`timescale 1ns/1ps
// One channel: moving average over 2^D samples or first-order IIR.
module adcdc_chan #(
	parameter int W = 24
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic sample_valid,
	input wire logic signed [W-1:0] sample,
	adcdc_chan_if.chan cfg,
	output logic [W-1:0] result,
	output logic result_valid
);
	localparam int AW = adcdc_pkg::ACC_W;

	logic signed [AW-1:0] acc;
	logic [20:0] count;
	logic [20:0] clr_count;
	logic signed [AW-1:0] sample_ext;
	logic signed [AW-1:0] iir_step;
	logic signed [AW-1:0] next_acc;
	logic [20:0] win_len;
	logic [20:0] clr_len;
	logic win_done;
	logic clr_due;
	logic signed [AW-1:0] ma_sum;
	logic signed [AW-1:0] iir_out;

	assign sample_ext = AW'(sample);
	assign win_len = 21'(21'h1 << cfg.d_shift);
	assign clr_len = 21'(21'h1 << cfg.avg_code);
	assign win_done = (count + 21'h1) >= win_len;
	// Code zero means infinite averaging: clr_due never fires, so no periodic clear.
	assign clr_due = cfg.mod_tick && (cfg.avg_code != 5'h00)
		&& ((clr_count + 21'h1) >= clr_len);
	// IIR: acc += (x - acc) >> D, so acc tracks the DC level directly.
	assign iir_step = (sample_ext - acc) >>> cfg.d_shift;
	assign next_acc = acc + iir_step;
	assign ma_sum = acc + sample_ext;
	assign iir_out = cfg.preclear ? acc : next_acc;

	// ---------------------------------------------------------------
	// Filter state
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc <= '0;
			count <= '0;
			clr_count <= '0;
			result <= '0;
			result_valid <= 1'b0;
		end
		else
		begin
			result_valid <= 1'b0;
			if (cfg.mod_tick)
				clr_count <= clr_due ? 21'h0 : clr_count + 21'h1;
			if (!enable)
			begin
				acc <= '0;
				count <= '0;
			end
			else if (!cfg.iir_sel && sample_valid)
			begin
				if (win_done)
				begin
					result <= W'(ma_sum >>> cfg.d_shift);
					result_valid <= 1'b1;
					acc <= '0;
					count <= '0;
				end
				else
				begin
					acc <= ma_sum;
					count <= count + 21'h1;
				end
			end
			else if (cfg.iir_sel)
			begin
				if (clr_due)
				begin
					acc <= '0;
					if (cfg.preclear)
					begin
						result <= W'(acc);
						result_valid <= 1'b1;
					end
				end
				else if (sample_valid)
				begin
					acc <= next_acc;
					if (!cfg.preclear)
					begin
						result <= W'(iir_out);
						result_valid <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// [rtl/adcdc_chan_if.sv]
`timescale 1ns/1ps
// Shared configuration from the register file, plus the modulator tick, into each channel filter.
interface adcdc_chan_if;
	logic iir_sel;
	logic preclear;
	logic [4:0] d_shift;
	logic [4:0] avg_code;
	logic mod_tick;

	modport ctrl (output iir_sel, output preclear, output d_shift,
		output avg_code, output mod_tick);
	modport chan (input iir_sel, input preclear, input d_shift,
		input avg_code, input mod_tick);
endinterface

// [rtl/adcdc_pkg.sv]
package adcdc_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_PAGE = 8'h00;
	localparam logic [7:0] ADDR_CFG_ONE = 8'h66;
	localparam logic [7:0] ADDR_CFG_TWO = 8'h67;
	localparam logic [7:0] ADDR_LEFT_HIGH = 8'h68;
	localparam logic [7:0] ADDR_LEFT_MID = 8'h69;
	localparam logic [7:0] ADDR_LEFT_LOW = 8'h6a;
	localparam logic [7:0] ADDR_RIGHT_HIGH = 8'h6b;
	localparam logic [7:0] ADDR_RIGHT_MID = 8'h6c;
	localparam logic [7:0] ADDR_RIGHT_LOW = 8'h6d;
	localparam logic [7:0] MEAS_PAGE = 8'h00;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CFG1_LEFT_EN_BIT = 7;
	localparam int CFG1_RIGHT_EN_BIT = 6;
	localparam int CFG1_IIR_SEL_BIT = 5;
	localparam int CFG2_HOLD_BIT = 6;
	localparam int CFG2_PRECLR_BIT = 5;
	localparam int FIELD_MSB = 4;
	localparam logic [7:0] CFG1_RESET = 8'h00;
	localparam logic [7:0] CFG2_RESET = 8'h00;
	localparam logic [7:0] CFG2_WMASK = 8'h7f;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [4:0] CODE_MAX = 5'h14;
	localparam logic [4:0] CODE_MIN_D = 5'h01;
	localparam int RESULT_W = 24;
	localparam int ACC_W = 48;

endpackage

// [rtl/adcdc_top.sv]
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module adcdc_top #(
	parameter int W = adcdc_pkg::RESULT_W
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic mod_clk_pin,
	input wire logic sample_valid,
	input wire logic [W-1:0] left_sample,
	input wire logic [W-1:0] right_sample,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic left_active,
	output logic right_active
);
	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	logic [7:0] page_sel;
	logic [7:0] dc_measure_config_one;
	logic [7:0] dc_measure_config_two;
	logic [W-1:0] left_vis;
	logic [W-1:0] right_vis;
	logic [W-1:0] left_pend;
	logic [W-1:0] right_pend;
	logic left_pend_v;
	logic right_pend_v;
	logic [1:0] mod_sync;
	logic mod_prev;
	logic [W-1:0] left_res;
	logic [W-1:0] right_res;
	logic left_res_v;
	logic right_res_v;
	logic [7:0] next_rdata;

	wire on_page = page_sel == adcdc_pkg::MEAS_PAGE;
	wire wr_page = reg_wr && reg_addr == adcdc_pkg::ADDR_PAGE;
	wire wr_cfg1 = reg_wr && on_page
		&& reg_addr == adcdc_pkg::ADDR_CFG_ONE;
	wire wr_cfg2 = reg_wr && on_page
		&& reg_addr == adcdc_pkg::ADDR_CFG_TWO;
	wire left_en = dc_measure_config_one[adcdc_pkg::CFG1_LEFT_EN_BIT];
	wire right_en = dc_measure_config_one[adcdc_pkg::CFG1_RIGHT_EN_BIT];
	wire hold = dc_measure_config_two[adcdc_pkg::CFG2_HOLD_BIT];
	wire [4:0] d_code = dc_measure_config_one[adcdc_pkg::FIELD_MSB:0];
	wire [4:0] avg_code = dc_measure_config_two[adcdc_pkg::FIELD_MSB:0];
	// A result read spans three byte reads; hold the value while any
	// result byte of the page is being read so the bytes belong together.
	wire res_rd = reg_rd && on_page
		&& reg_addr >= adcdc_pkg::ADDR_LEFT_HIGH
		&& reg_addr <= adcdc_pkg::ADDR_RIGHT_LOW;
	wire freeze = hold && res_rd;

	// Reserved D codes are clamped so the hardware stays bounded.
	wire [4:0] d_safe = (d_code < adcdc_pkg::CODE_MIN_D)
		? adcdc_pkg::CODE_MIN_D
		: (d_code > adcdc_pkg::CODE_MAX) ? adcdc_pkg::CODE_MAX
		: d_code;
	wire [4:0] avg_safe = (avg_code > adcdc_pkg::CODE_MAX)
		? adcdc_pkg::CODE_MAX : avg_code;

	adcdc_chan_if cfg_bus ();
	assign cfg_bus.iir_sel =
		dc_measure_config_one[adcdc_pkg::CFG1_IIR_SEL_BIT];
	assign cfg_bus.preclear =
		dc_measure_config_two[adcdc_pkg::CFG2_PRECLR_BIT];
	assign cfg_bus.d_shift = d_safe;
	assign cfg_bus.avg_code = avg_safe;
	assign cfg_bus.mod_tick = mod_sync[1] && !mod_prev;

	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------
	adcdc_chan #(.W(W)) u_left (
		.core_clk(core_clk),
		.resetn(resetn),
		.enable(left_en),
		.sample_valid(sample_valid),
		.sample(left_sample),
		.cfg(cfg_bus),
		.result(left_res),
		.result_valid(left_res_v)
	);

	adcdc_chan #(.W(W)) u_right (
		.core_clk(core_clk),
		.resetn(resetn),
		.enable(right_en),
		.sample_valid(sample_valid),
		.sample(right_sample),
		.cfg(cfg_bus),
		.result(right_res),
		.result_valid(right_res_v)
	);

	// The modulator clock pin is sampled; only its rising edge is used.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mod_sync <= 2'b00;
			mod_prev <= 1'b0;
		end
		else
		begin
			mod_sync <= {mod_sync[0], mod_clk_pin};
			mod_prev <= mod_sync[1];
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			page_sel <= adcdc_pkg::PAGE_RESET;
			dc_measure_config_one <= adcdc_pkg::CFG1_RESET;
			dc_measure_config_two <= adcdc_pkg::CFG2_RESET;
		end
		else
		begin
			if (wr_page)
				page_sel <= reg_wdata;
			if (wr_cfg1)
				dc_measure_config_one <= reg_wdata;
			if (wr_cfg2)
				dc_measure_config_two <= reg_wdata & adcdc_pkg::CFG2_WMASK;
		end
	end

	// ---------------------------------------------------------------
	// Visible results with hold
	// ---------------------------------------------------------------
	// Channels only raise result_valid while enabled, so a disabled
	// channel leaves its visible value untouched.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			left_vis <= '0;
			right_vis <= '0;
			left_pend <= '0;
			right_pend <= '0;
			left_pend_v <= 1'b0;
			right_pend_v <= 1'b0;
		end
		else
		begin
			if (left_res_v && left_en)
			begin
				left_pend <= left_res;
				left_pend_v <= 1'b1;
			end
			else if (!freeze && left_pend_v)
				left_pend_v <= 1'b0;
			if (right_res_v && right_en)
			begin
				right_pend <= right_res;
				right_pend_v <= 1'b1;
			end
			else if (!freeze && right_pend_v)
				right_pend_v <= 1'b0;
			if (!freeze && left_pend_v)
				left_vis <= left_pend;
			if (!freeze && right_pend_v)
				right_vis <= right_pend;
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_comb
	begin
		next_rdata = 8'h00;
		if (reg_addr == adcdc_pkg::ADDR_PAGE)
			next_rdata = page_sel;
		else if (on_page)
		begin
			case (reg_addr)
				adcdc_pkg::ADDR_CFG_ONE: next_rdata = dc_measure_config_one;
				adcdc_pkg::ADDR_CFG_TWO: next_rdata = dc_measure_config_two;
				adcdc_pkg::ADDR_LEFT_HIGH: next_rdata = left_vis[23:16];
				adcdc_pkg::ADDR_LEFT_MID: next_rdata = left_vis[15:8];
				adcdc_pkg::ADDR_LEFT_LOW: next_rdata = left_vis[7:0];
				adcdc_pkg::ADDR_RIGHT_HIGH: next_rdata = right_vis[23:16];
				adcdc_pkg::ADDR_RIGHT_MID: next_rdata = right_vis[15:8];
				adcdc_pkg::ADDR_RIGHT_LOW: next_rdata = right_vis[7:0];
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			reg_rdata <= 8'h00;
			left_active <= 1'b0;
			right_active <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
			left_active <= left_en;
			right_active <= right_en;
		end
	end
endmodule

// [verif/adcdc_chk.sv]
`timescale 1ns/1ps
module adcdc_chk #(
	parameter int W = 24
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic mod_clk_pin,
	input wire logic sample_valid,
	input wire logic [W-1:0] left_sample,
	input wire logic [W-1:0] right_sample,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic left_active,
	input wire logic right_active
);
	logic [7:0] pg;
	wire p0 = pg == 8'h00;
	wire cfg_wr = reg_wr && p0 && reg_addr == 8'h66;
	always_ff @(posedge core_clk or negedge resetn)
		if (!resetn)
			pg <= 8'h00;
		else if (reg_wr && reg_addr == 8'h00)
			pg <= reg_wdata;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_rd_quiet: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
		else $error("read data outside a read slot");
	// The enable copies sit one register behind the configuration byte.
	a_left_enable: assert property (cfg_wr |=> ##1
		left_active == $past(reg_wdata[7], 2)) else $error("left enable");
	a_right_enable: assert property (cfg_wr |=> ##1
		right_active == $past(reg_wdata[6], 2)) else $error("right enable");
	a_enable_hold: assert property (!cfg_wr |=> ##1
		$stable({left_active, right_active})) else $error("enable moved");
	a_cfg_readback: assert property (reg_rd && p0 && reg_addr == 8'h66 |=>
		reg_rdata[7:6] == {left_active, right_active})
		else $error("config one readback");
	a_cfg_reserved: assert property (reg_rd && reg_addr == 8'h67 |=>
		!reg_rdata[7]) else $error("reserved bit set");
	a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h6d |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_page_read: assert property (reg_rd && reg_addr == 8'h00 |=>
		reg_rdata == $past(pg)) else $error("page readback");
	c_cfg: cover property (cfg_wr);
	c_res: cover property (reg_rd && reg_addr == 8'h68);
	c_page: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata != 8'h00);
endmodule
bind adcdc_top adcdc_chk #(.W(W)) chk_i (.core_clk(core_clk),
	.resetn(resetn), .mod_clk_pin(mod_clk_pin), .sample_valid(sample_valid),
	.left_sample(left_sample), .right_sample(right_sample),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .left_active(left_active),
	.right_active(right_active));

// [verif/adcdc_host.sv]
`timescale 1ns/1ps
module adcdc_host (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// Data is taken just after the edge that registers it, once it settled.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// [verif/adcdc_tb_top.sv]
`timescale 1ns/1ps
module adcdc_tb_top;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic mod_clk_pin = 1'b0;
	logic sample_valid = 1'b0;
	logic [23:0] left_sample = 24'h000000;
	logic [23:0] right_sample = 24'h000000;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, left_active, right_active;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk)
		mod_clk_pin <= ~mod_clk_pin;
	adcdc_top uut (.core_clk(core_clk), .resetn(resetn),
		.mod_clk_pin(mod_clk_pin), .sample_valid(sample_valid),
		.left_sample(left_sample), .right_sample(right_sample),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .left_active(left_active),
		.right_active(right_active));
	adcdc_host host (.core_clk(core_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd));
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			error_cnt++;
			conclude();
		end
	end
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rc(logic [7:0] a, logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// A few idle cycles after the last sample let the result settle.
	task automatic feed(logic [23:0] l, logic [23:0] r, int n);
		repeat (n)
		begin
			@(posedge core_clk);
			left_sample <= l;
			right_sample <= r;
			sample_valid <= 1'b1;
			@(posedge core_clk);
			sample_valid <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
	endtask
	task automatic t_reset();
		for (int a = 8'h66; a <= 8'h6d; a++)
			rc(8'(a), 8'h00);
		for (int a = 8'h68; a <= 8'h6d; a++)
		begin
			host.wr(8'(a), 8'hff);
			rc(8'(a), 8'h00);
		end
		rc(8'h70, 8'h00);
		host.wr(8'h67, 8'hff);
		rc(8'h67, 8'h7f);
		host.wr(8'h67, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_avg();
		host.wr(8'h66, 8'h81);
		feed(24'h123456, 24'h654321, 2);
		rc(8'h68, 8'h12);
		rc(8'h69, 8'h34);
		rc(8'h6a, 8'h56);
		rc(8'h6b, 8'h00);
		chk("left_active", 8'h01, {7'h00, left_active});
		host.wr(8'h66, 8'hc1);
		feed(24'h123456, 24'h654321, 2);
		rc(8'h6b, 8'h65);
		rc(8'h6c, 8'h43);
		rc(8'h6d, 8'h21);
		$display("average test done");
	endtask
	task automatic t_keep();
		host.wr(8'h66, 8'h41);
		feed(24'h000777, 24'h000777, 2);
		rc(8'h68, 8'h12);
		rc(8'h6a, 8'h56);
		rc(8'h6c, 8'h07);
		rc(8'h6d, 8'h77);
		chk("left_active", 8'h00, {7'h00, left_active});
		chk("right_active", 8'h01, {7'h00, right_active});
		$display("disable test done");
	endtask
	task automatic t_iir();
		host.wr(8'h66, 8'h00);
		host.wr(8'h66, 8'ha1);
		feed(24'h200000, 24'h000000, 1);
		rc(8'h68, 8'h10);
		feed(24'h200000, 24'h000000, 1);
		rc(8'h68, 8'h18);
		host.wr(8'h67, 8'h20);
		feed(24'h000000, 24'h000000, 3);
		rc(8'h68, 8'h18);
		$display("iir test done");
	endtask
	task automatic t_page();
		host.wr(8'h00, 8'h01);
		host.wr(8'h66, 8'h00);
		rc(8'h00, 8'h01);
		host.wr(8'h00, 8'h00);
		rc(8'h66, 8'ha1);
		$display("page test done");
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		t_avg();
		t_keep();
		t_iir();
		t_page();
		conclude();
	end
endmodule
